/* rtl/bgc_gauge_regs.sv */
// Register bank and control of the battery gauge, reached over the two-wire serial bus.
// Assumes an external converter and charge algorithm on clk; bus pins are asynchronous.
// Function
// - Restart on pin rising edge (select pin low, not asleep) or mode write
// - Restart reruns estimate from starting state
// - Power-up estimate seeded by first conversion
// - Select pin high: external clock, oscillator off
// - Both lines low 2.5s enters sleep
// - Line rising edge exits sleep, state kept
// - Command 0054h resets whole device
// - Reset at last bit, no acknowledge
// - Only complete 16-bit writes take effect
// - Unmapped reads return arbitrary data
// - Voltage register holds 12-bit result
// - Step 1.25mV single, 2.50mV dual cell
// - Average 125ms first, then 500ms
// - Charge: percent high byte, fraction low
// - First charge value within 250ms
// - Charge saturates at register limits
// - Mode register write-only, 4000h only
// - Version register returns fixed revision
// - Compensation resets 9700h, feeds algorithm
// - Command register write-only, 0054h only
// - Most significant byte first, even address
// - Answer only target address 0110110
// - Sleep entry between 1.75s and 2.5s
`timescale 1ns/100ps
module bgc_gauge_regs
  import bgc_pkg::*;
#(
  parameter int          OSC_DIV_P   = OSC_DIV,
  parameter int          SLEEP_CYC_P = SLEEP_CYC,
  parameter int          FIRST_TICKS = FIRST_CONV_TICKS,
  parameter int          CONV_TICKS_P = CONV_TICKS,
  parameter int          DUE_TICKS   = CHARGE_DUE_TICKS,
  parameter bit          DUAL_CELL   = 1'b0,
  // Arbitrary revision value.
  parameter logic [15:0] REVISION_ID = 16'h0001
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       scl_pin,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe,
  input  wire logic                       clock_select_pin,
  input  wire logic                       clock_or_restart_pin,
  input  wire logic [SAMPLE_W-1:0]        adc_sample,
  input  wire logic signed [CHARGE_W-1:0] charge_raw,
  input  wire logic                       charge_valid,
  output logic [VOLT_W-1:0]               battery_voltage_result,
  output logic [15:0]                     charge_level_result,
  output logic [15:0]                     model_compensation,
  output logic                            estimate_restart,
  output logic                            first_conversion,
  output logic                            gauge_run,
  output logic                            sleep_active
);

  localparam int FIRST_SHIFT = $clog2(FIRST_TICKS);
  localparam int CONV_SHIFT  = $clog2(CONV_TICKS_P);
  localparam int MAX_SHIFT   = (FIRST_SHIFT > CONV_SHIFT) ? FIRST_SHIFT : CONV_SHIFT;
  localparam int ACC_W       = SAMPLE_W + MAX_SHIFT;
  localparam int CW          = MAX_SHIFT + 1;
  localparam int DUW         = $clog2(DUE_TICKS) + 1;
  localparam int SW          = $clog2(SLEEP_CYC_P) + 1;

  if ((1 << FIRST_SHIFT) != FIRST_TICKS || (1 << CONV_SHIFT) != CONV_TICKS_P) begin : g_chk_pow
    $error("bgc_gauge_regs: conversion periods must be powers of two ticks");
  end
  if (SLEEP_CYC_P < 1 || DUE_TICKS < 1) begin : g_chk_cnt
    $error("bgc_gauge_regs: sleep and charge deadline counts must be positive");
  end

  typedef struct packed {
    bgc_bus_st_t       st;
    logic [2:0]        bit_n;
    logic [7:0]        sh;
    logic              rw;
    logic              addr_phase;
    logic [7:0]        ptr;
    logic [7:0]        hi;
    logic              hi_ok;
    logic [7:0]        snap;
    logic              snap_ok;
    logic              oe;
    logic              ack_on;
    logic [15:0]       comp;
    logic [VOLT_W-1:0] volt;
    logic [15:0]       charge;
    logic              charged;
    logic              first;
    logic [ACC_W-1:0]  acc;
    logic [CW-1:0]     conv_n;
    logic [DUW-1:0]    due_n;
    logic [SW-1:0]     sleep_n;
    logic              sleep;
    logic              restart;
    logic              first_conv;
    logic              por;
  } bgc_core_t;

  // Reset state also raises the restart pulse so the algorithm starts fresh.
  localparam bgc_core_t RST = '{st: ST_IDLE, comp: COMP_RESET, restart: 1'b1, first: 1'b1, default: '0};

  function automatic logic [15:0] reg_word(input logic [7:0] a, input logic [VOLT_W-1:0] v,
                                           input logic [15:0] c, input logic [15:0] k);
    logic [15:0] w;
    w = '0;
    unique case (a)
      REG_VOLT:   w = {{(16 - VOLT_W){1'b0}}, v};
      REG_CHARGE: w = c;
      REG_REV:    w = REVISION_ID;
      REG_COMP:   w = k;
      // write-only read zero; unmapped reads zero
      default:    w = '0;
    endcase
    return w;
  endfunction : reg_word

  function automatic logic [15:0] sat_charge(input logic signed [CHARGE_W-1:0] r);
    logic [15:0] s;
    if (r < 0) begin
      s = '0;
    end else if (r > $signed({{(CHARGE_W - 16){1'b0}}, 16'hFFFF})) begin
      s = 16'hFFFF;
    end else begin
      s = r[15:0];
    end
    return s;
  endfunction : sat_charge

  bgc_pin_if pins ();

  bgc_pin_cond #(
    .DIV (OSC_DIV_P)
  ) u_cond (
    .clk                  (clk),
    .rst_b                (rst_b),
    .scl_pin              (scl_pin),
    .sda_pin              (sda_in),
    .clock_select_pin     (clock_select_pin),
    .clock_or_restart_pin (clock_or_restart_pin),
    .pins                 (pins.cond)
  );

  bgc_core_t            q;
  bgc_core_t            d;
  logic [15:0]          rd_word;
  logic [7:0]           ld_byte;
  logic [7:0]           rx_byte;
  logic [15:0]          wr_word;
  logic [7:0]           wr_addr;
  logic                 restart_req;
  logic                 run;
  logic [ACC_W-1:0]     acc_nx;
  logic [SAMPLE_W-1:0]  avg;

  always_comb begin
    d            = q;
    d.restart    = 1'b0;
    d.first_conv = 1'b0;
    restart_req  = 1'b0;
    run          = ~q.sleep;
    rx_byte      = {q.sh[6:0], pins.sda};
    wr_word      = {q.hi, rx_byte};
    wr_addr      = {q.ptr[7:1], 1'b0};
    acc_nx       = q.acc + ACC_W'(adc_sample);
    avg          = '0;
    // high byte at even address, sent first
    rd_word = reg_word(wr_addr, q.volt, q.charge, q.comp);
    ld_byte = q.ptr[0] ? (q.snap_ok ? q.snap : rd_word[7:0]) : rd_word[15:8];

    if (!pins.scl && !pins.sda) begin
      if (q.sleep_n == SW'(SLEEP_CYC_P - 1)) begin
        d.sleep = 1'b1;
      end else begin
        d.sleep_n = q.sleep_n + SW'(1);
      end
    end else begin
      d.sleep_n = '0;
    end
    if (pins.scl_rise || pins.sda_rise) begin
      d.sleep = 1'b0;
    end

    if (pins.scl && pins.sda_fall) begin
      d.st    = ST_ADDR;
      d.bit_n = '0;
      d.oe    = 1'b0;
    end else if (pins.scl && pins.sda_rise) begin
      d.st    = ST_IDLE;
      d.oe    = 1'b0;
      d.hi_ok = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
        end
        ST_ADDR, ST_RX: begin
          if (pins.scl_rise) begin
            d.sh    = rx_byte;
            d.bit_n = q.bit_n + 3'd1;
            if (q.bit_n == 3'd7) begin
              d.st     = ST_ACK;
              d.ack_on = 1'b0;
              if (q.st == ST_ADDR) begin
                if (rx_byte[7:1] == DEV_ADDR) begin
                  d.rw         = rx_byte[0];
                  d.addr_phase = ~rx_byte[0];
                end else begin
                  d.st = ST_IDLE;
                end
              end else if (q.addr_phase) begin
                d.ptr        = rx_byte;
                d.addr_phase = 1'b0;
                d.hi_ok      = 1'b0;
                d.snap_ok    = 1'b0;
              end else if (!q.ptr[0]) begin
                d.hi    = rx_byte;
                d.hi_ok = 1'b1;
                d.ptr   = q.ptr + 8'd1;
              end else begin
                d.hi_ok = 1'b0;
                d.ptr   = q.ptr + 8'd1;
                if (q.hi_ok) begin
                  if (wr_addr == REG_COMP) begin
                    d.comp = wr_word;
                  end
                  if (wr_addr == REG_MODE && wr_word == MODE_RESTART) begin
                    restart_req = 1'b1;
                  end
                  if (wr_addr == REG_CMD && wr_word == CMD_FULL_RESET) begin
                    d.por = 1'b1;
                    d.st  = ST_IDLE;
                  end
                end
              end
            end
          end
        end
        ST_ACK: begin
          if (pins.scl_fall) begin
            if (!q.ack_on) begin
              d.oe     = 1'b1;
              d.ack_on = 1'b1;
            end else begin
              d.ack_on = 1'b0;
              d.bit_n  = '0;
              if (q.rw) begin
                d.st   = ST_TX;
                d.sh   = ld_byte;
                d.oe   = ~ld_byte[7];
                d.ptr  = q.ptr + 8'd1;
                if (!q.ptr[0]) begin
                  d.snap    = rd_word[7:0];
                  d.snap_ok = 1'b1;
                end
              end else begin
                d.st = ST_RX;
                d.oe = 1'b0;
              end
            end
          end
        end
        ST_TX: begin
          if (pins.scl_fall) begin
            if (q.bit_n == 3'd7) begin
              d.oe = 1'b0;
              d.st = ST_TX_ACK;
            end else begin
              d.bit_n = q.bit_n + 3'd1;
              d.sh    = {q.sh[6:0], 1'b0};
              d.oe    = ~q.sh[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (pins.scl_rise) begin
            d.st = pins.sda ? ST_IDLE : ST_TX_LOAD;
          end
        end
        ST_TX_LOAD: begin
          if (pins.scl_fall) begin
            d.st    = ST_TX;
            d.bit_n = '0;
            d.sh    = ld_byte;
            d.oe    = ~ld_byte[7];
            d.ptr   = q.ptr + 8'd1;
            if (!q.ptr[0]) begin
              d.snap    = rd_word[7:0];
              d.snap_ok = 1'b1;
            end
          end
        end
      endcase
    end

    if (run && pins.tick) begin
      d.acc = acc_nx;
      if (q.conv_n == (q.first ? CW'(FIRST_TICKS - 1) : CW'(CONV_TICKS_P - 1))) begin
        avg = q.first ? SAMPLE_W'(acc_nx >> FIRST_SHIFT) : SAMPLE_W'(acc_nx >> CONV_SHIFT);
        if (DUAL_CELL) begin
          d.volt = avg[SAMPLE_W-1:1];
        end else begin
          d.volt = avg[SAMPLE_W-1] ? {VOLT_W{1'b1}} : avg[VOLT_W-1:0];
        end
        d.first_conv = q.first;
        d.first      = 1'b0;
        d.acc        = '0;
        d.conv_n     = '0;
      end else begin
        d.conv_n = q.conv_n + CW'(1);
      end
    end

    if (run && charge_valid) begin
      d.charge  = sat_charge(charge_raw);
      d.charged = 1'b1;
    end else if (run && pins.tick && !q.charged) begin
      if (q.due_n == DUW'(DUE_TICKS - 1)) begin
        d.charge  = sat_charge(charge_raw);
        d.charged = 1'b1;
      end else begin
        d.due_n = q.due_n + DUW'(1);
      end
    end

    if (restart_req || (run && pins.eo_rise)) begin
      d.restart = 1'b1;
      d.first   = 1'b1;
      d.acc     = '0;
      d.conv_n  = '0;
      d.due_n   = '0;
      d.charged = 1'b0;
    end

    if (q.por) begin
      d = RST;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign sda_out                = 1'b0;
  assign sda_oe                 = q.oe;
  assign battery_voltage_result = q.volt;
  assign charge_level_result    = q.charge;
  assign model_compensation     = q.comp;
  assign estimate_restart       = q.restart;
  assign first_conversion       = q.first_conv;
  assign gauge_run              = ~q.sleep;
  assign sleep_active           = q.sleep;

endmodule : bgc_gauge_regs

/* common/bgc_pkg.sv */
// Constants, register map and bus states for the battery gauge control block.
// Assumes a single 125 MHz clock; sleep time is counted in its cycles, conversion and charge times in 32768 Hz ticks.
package bgc_pkg;

  localparam int CLK_HZ          = 125_000_000;
  localparam int OSC_HZ          = 32_768;
  localparam int OSC_DIV         = CLK_HZ / OSC_HZ;

  localparam int FIRST_CONV_MS   = 125;
  localparam int CONV_MS         = 500;
  localparam int CHARGE_DUE_MS   = 250;
  localparam int SLEEP_MS        = 2500;
  localparam int FIRST_CONV_TICKS = OSC_HZ * FIRST_CONV_MS / 1000;
  localparam int CONV_TICKS       = OSC_HZ * CONV_MS / 1000;
  localparam int CHARGE_DUE_TICKS = OSC_HZ * CHARGE_DUE_MS / 1000;
  localparam int SLEEP_CYC        = (CLK_HZ / 1000) * SLEEP_MS;

  localparam logic [7:0]  REG_VOLT     = 8'h02;
  localparam logic [7:0]  REG_CHARGE   = 8'h04;
  localparam logic [7:0]  REG_MODE     = 8'h06;
  localparam logic [7:0]  REG_REV      = 8'h08;
  localparam logic [7:0]  REG_COMP     = 8'h0C;
  localparam logic [7:0]  REG_CMD      = 8'hFE;

  localparam logic [15:0] COMP_RESET     = 16'h9700;
  localparam logic [15:0] MODE_RESTART   = 16'h4000;
  localparam logic [15:0] CMD_FULL_RESET = 16'h0054;
  localparam logic [6:0]  DEV_ADDR       = 7'h36;

  localparam int VOLT_W   = 12;
  localparam int SAMPLE_W = 13;
  localparam int CHARGE_W = 18;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TX_ACK, ST_TX_LOAD
  } bgc_bus_st_t;

endpackage : bgc_pkg

/* common/bgc_pin_if.sv */
// Conditioned pin levels, edges and the 32 kHz tick passed to the core.
// Assumes producer and consumer share clk.
`timescale 1ns/100ps
interface bgc_pin_if;
  logic scl;
  logic sda;
  logic sel;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic eo_rise;
  logic tick;

  modport cond (output scl, sda, sel, scl_rise, scl_fall, sda_rise, sda_fall, eo_rise, tick);
  modport core (input scl, sda, sel, scl_rise, scl_fall, sda_rise, sda_fall, eo_rise, tick);
endinterface : bgc_pin_if

/* rtl/bgc_pin_cond.sv */
// Pin synchronisers, edge detection and the 32 kHz time base.
// Assumes all pins are asynchronous to clk.
`timescale 1ns/100ps
module bgc_pin_cond
  import bgc_pkg::*;
#(
  parameter int DIV = OSC_DIV
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  input  wire logic clock_select_pin,
  input  wire logic clock_or_restart_pin,
  bgc_pin_if.cond   pins
);

  localparam int DW = $clog2(DIV);

  if (DIV < 2) begin : g_chk
    $error("bgc_pin_cond: DIV must be at least 2");
  end

  typedef struct packed {
    logic [1:0]    s_scl;
    logic [1:0]    s_sda;
    logic [1:0]    s_sel;
    logic [1:0]    s_eo;
    logic          scl_p;
    logic          sda_p;
    logic          eo_p;
    logic [DW-1:0] div;
    logic          tick;
  } bgc_cond_t;

  localparam bgc_cond_t RST = '{s_scl: 2'b11, s_sda: 2'b11, scl_p: 1'b1, sda_p: 1'b1, default: '0};

  bgc_cond_t q;
  bgc_cond_t d;

  always_comb begin
    d       = q;
    d.s_scl = {q.s_scl[0], scl_pin};
    d.s_sda = {q.s_sda[0], sda_pin};
    d.s_sel = {q.s_sel[0], clock_select_pin};
    d.s_eo  = {q.s_eo[0], clock_or_restart_pin};
    d.scl_p = q.s_scl[1];
    d.sda_p = q.s_sda[1];
    d.eo_p  = q.s_eo[1];
    d.tick  = 1'b0;
    if (q.s_sel[1]) begin
      d.div  = '0;
      d.tick = q.s_eo[1] & ~q.eo_p;
    end else if (q.div == DW'(DIV - 1)) begin
      d.div  = '0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + DW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign pins.scl      = q.s_scl[1];
  assign pins.sda      = q.s_sda[1];
  assign pins.sel      = q.s_sel[1];
  assign pins.scl_rise = q.s_scl[1] & ~q.scl_p;
  assign pins.scl_fall = ~q.s_scl[1] & q.scl_p;
  assign pins.sda_rise = q.s_sda[1] & ~q.sda_p;
  assign pins.sda_fall = ~q.s_sda[1] & q.sda_p;
  // restart edge only without external clock
  assign pins.eo_rise  = q.s_eo[1] & ~q.eo_p & ~q.s_sel[1];
  assign pins.tick     = q.tick;

endmodule : bgc_pin_cond

/* testbench/bgc_host_model.sv */
// Two-wire bus master that the bench uses to reach the gauge registers.
// Assumes the bench resolves SDA from both pull-down enables with a pull-up.
`timescale 1ns/100ps
module bgc_host_model #(
  parameter int HALF = 8
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  // Lines change just after an edge and hold for a whole phase.
  task automatic put(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    sda_low <= ~d;
    wait_cyc(HALF);
  endtask : put

  // SDA moves only while SCL is low, so no false START or STOP is seen.
  task automatic put_bit(input logic d, output logic s);
    put(1'b0, ~sda_low);
    put(1'b0, d);
    put(1'b1, d);
    s = sda_line;
  endtask : put_bit

  task automatic start();
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
    put(1'b0, 1'b0);
  endtask : start

  task automatic stop();
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
  endtask : stop

  task automatic send_byte(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], nak);
    end
    put_bit(1'b1, nak);
  endtask : send_byte

  task automatic get_byte(input logic nak, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(nak, s);
  endtask : get_byte

  // Both lines driven low and left low on return, after one phase plus n cycles: the bus-parked condition.
  task automatic hold_low(input int n);
    put(1'b0, 1'b0);
    wait_cyc(n);
  endtask : hold_low
endmodule : bgc_host_model

/* testbench/bgc_gauge_regs_assertions.sv */
// Concurrent checks on the ports of the gauge register block.
// Assumes one clock domain; bound from the bench top file.
`timescale 1ns/100ps
module bgc_gauge_regs_assertions
  import bgc_pkg::*;
#(
  parameter int OSC_DIV_P   = 4,
  parameter int SLEEP_CYC_P = 200,
  parameter int FIRST_TICKS = 4
) (
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire logic                       scl_pin,
  input wire logic                       sda_in,
  input wire logic                       sda_oe,
  input wire logic                       clock_select_pin,
  input wire logic                       clock_or_restart_pin,
  input wire logic signed [CHARGE_W-1:0] charge_raw,
  input wire logic                       charge_valid,
  input wire logic [VOLT_W-1:0]          battery_voltage_result,
  input wire logic [15:0]                charge_level_result,
  input wire logic [15:0]                model_compensation,
  input wire logic                       estimate_restart,
  input wire logic                       first_conversion,
  input wire logic                       gauge_run,
  input wire logic                       sleep_active
);
  localparam int F_LO   = (FIRST_TICKS - 2) * OSC_DIV_P;
  localparam int F_HI   = (FIRST_TICKS + 2) * OSC_DIV_P + 8;
  localparam int S_MIN  = SLEEP_CYC_P * 7 / 10;
  localparam int S_LATE = SLEEP_CYC_P + 6;
  logic [31:0] low_cnt_q;
  logic [15:0] charge_exp_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= 32'h0;
      charge_exp_q <= 16'h0000;
    end else begin
      low_cnt_q <= (scl_pin || sda_in) ? 32'h0 : low_cnt_q + 32'h1;
      if (charge_valid) begin
        charge_exp_q <= (charge_raw < 0) ? 16'h0000 : (charge_raw > 18'sh0FFFF) ? 16'hFFFF : charge_raw[15:0];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_pin_rise;
    $rose(clock_or_restart_pin) && !clock_select_pin && gauge_run;
  endsequence
  sequence s_ext_steady;
    (clock_select_pin && scl_pin)[*8];
  endsequence
  sequence s_restart_end;
    $fell(estimate_restart) && !clock_select_pin;
  endsequence

  a_reset_values: assert property (
    $rose(rst_b) |-> model_compensation == COMP_RESET && estimate_restart)
    else $error("compensation or restart flag wrong after reset");
  a_pin_restart: assert property (
    s_pin_rise |-> ##[2:6] estimate_restart)
    else $error("restart pin edge gave no restart");
  a_ext_no_restart: assert property (
    s_ext_steady |-> !estimate_restart)
    else $error("restart while running from external clock");
  a_first_window: assert property (
    s_restart_end |-> ##[F_LO:F_HI] first_conversion)
    else $error("first conversion not stored in time");
  a_sleep_late: assert property (
    low_cnt_q >= 32'(S_LATE) |-> sleep_active)
    else $error("not asleep after parked bus time");
  a_sleep_early: assert property (
    $rose(sleep_active) |-> low_cnt_q >= 32'(S_MIN))
    else $error("sleep entered too early");
  a_sleep_wake: assert property (
    sleep_active && ($rose(scl_pin) || $rose(sda_in)) |-> ##[1:6] !sleep_active)
    else $error("line rise did not end sleep");
  a_sleep_halt: assert property (
    sleep_active && $past(sleep_active) |-> $stable(battery_voltage_result) && !first_conversion)
    else $error("conversion ran while asleep");
  a_charge_store: assert property (
    $past(charge_valid && gauge_run) |-> ##[0:1] charge_level_result == charge_exp_q)
    else $error("charge register not the clamped value");
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl_pin)
    else $error("data line changed while clock high");
endmodule : bgc_gauge_regs_assertions

/* testbench/bgc_gauge_regs_tb_top.sv */
// Self-checking bench for the gauge register block over the two-wire bus.
// Assumes the host model for bus cycles and the checker bound below.
`timescale 1ns/100ps
module bgc_gauge_regs_tb_top
  import bgc_pkg::*;
();
  // Arbitrary revision value.
  localparam logic [15:0]        REV_ID     = 16'h0001;
  localparam int                 LIMIT      = 90000;
  localparam logic signed [17:0] CH_IN [3]  = '{18'sh3FFFB, 18'sh12345, 18'sh03280};
  localparam logic [15:0]        CH_EXP [3] = '{16'h0000, 16'hFFFF, 16'h3280};
  logic              clk = 1'b0;
  logic              ext_clk = 1'b0;
  logic              rst_b, sel, restart_q, ext_on, charge_valid;
  logic [12:0]       adc;
  logic signed [17:0] charge_raw;
  wire logic         scl, sda_low, sda_oe, link_pin, sda_line;
  wire logic [11:0]  volt;
  wire logic [15:0]  charge, comp;
  wire logic         est_restart, first_conv, gauge_run, sleep_active;
  int                n_mismatch, check_count, n_restart, cyc, r0;

  always #4 clk = ~clk;
  always #62.5 ext_clk = ext_on & ~ext_clk;
  assign link_pin = ext_on ? ext_clk : restart_q;
  assign sda_line = ~(sda_low | sda_oe);

  bgc_host_model u_bgc_host_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  bgc_gauge_regs #(.OSC_DIV_P(4), .SLEEP_CYC_P(200), .FIRST_TICKS(4), .CONV_TICKS_P(16), .DUE_TICKS(8))
    u_bgc_gauge_regs (
    .clk(clk), .rst_b(rst_b), .scl_pin(scl), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .clock_select_pin(sel), .clock_or_restart_pin(link_pin), .adc_sample(adc), .charge_raw(charge_raw),
    .charge_valid(charge_valid), .battery_voltage_result(volt), .charge_level_result(charge),
    .model_compensation(comp), .estimate_restart(est_restart), .first_conversion(first_conv),
    .gauge_run(gauge_run), .sleep_active(sleep_active));

  always @(posedge clk) begin
    if (rst_b && est_restart) begin
      n_restart++;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] v, input bit full, output logic nak);
    u_bgc_host_model.start();
    u_bgc_host_model.send_byte({DEV_ADDR, 1'b0}, nak);
    u_bgc_host_model.send_byte(a, nak);
    u_bgc_host_model.send_byte(v[15:8], nak);
    if (full) begin
      u_bgc_host_model.send_byte(v[7:0], nak);
    end
    u_bgc_host_model.stop();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    logic nak;
    u_bgc_host_model.start();
    u_bgc_host_model.send_byte({DEV_ADDR, 1'b0}, nak);
    u_bgc_host_model.send_byte(a, nak);
    u_bgc_host_model.start();
    u_bgc_host_model.send_byte({DEV_ADDR, 1'b1}, nak);
    u_bgc_host_model.get_byte(1'b0, v[15:8]);
    u_bgc_host_model.get_byte(1'b1, v[7:0]);
    u_bgc_host_model.stop();
  endtask : rd

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask : rd_chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    logic [15:0] v;
    logic        nak;
    rst_b = 1'b0;
    sel = 1'b0;
    restart_q = 1'b0;
    ext_on = 1'b0;
    adc = 13'h0A5A;
    charge_raw = 18'sh00000;
    charge_valid = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("compensation", REG_COMP, COMP_RESET);
    chk("comp_port", COMP_RESET, comp);
    rd_chk("revision", REG_REV, REV_ID);
    rd_chk("mode_read", REG_MODE, 16'h0000);
    rd_chk("command_read", REG_CMD, 16'h0000);
    rd(8'h0A, v);
    rd_chk("voltage", REG_VOLT, 16'h0A5A);
    $display("test reset_values finished");
    wr(REG_COMP, 16'h1234, 1'b1, nak);
    chk("comp_ack", 16'h0000, {15'h0000, nak});
    rd_chk("comp_rw", REG_COMP, 16'h1234);
    wr(REG_COMP, 16'hABCD, 1'b0, nak);
    rd_chk("comp_partial", REG_COMP, 16'h1234);
    wr(REG_REV, 16'hFFFF, 1'b1, nak);
    rd_chk("revision_ro", REG_REV, REV_ID);
    u_bgc_host_model.start();
    u_bgc_host_model.send_byte({7'h37, 1'b0}, nak);
    u_bgc_host_model.stop();
    chk("other_addr", 16'h0001, {15'h0000, nak});
    $display("test registers finished");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      charge_raw <= CH_IN[i];
      charge_valid <= 1'b1;
      @(posedge clk);
      charge_valid <= 1'b0;
      rd_chk("charge", REG_CHARGE, CH_EXP[i]);
    end
    $display("test charge finished");
    r0 = n_restart;
    wr(REG_MODE, MODE_RESTART, 1'b1, nak);
    wr(REG_MODE, 16'h4001, 1'b1, nak);
    chk("mode_restart", 16'h0001, 16'(n_restart - r0));
    @(posedge clk);
    restart_q <= 1'b1;
    charge_raw <= 18'sh100;
    repeat (10) @(posedge clk);
    restart_q <= 1'b0;
    repeat (10) @(posedge clk);
    chk("pin_restart", 16'h0002, 16'(n_restart - r0));
    $display("test restart finished");
    adc <= 13'h1800;
    repeat (200) @(posedge clk);
    chk("volt_sat", 16'h0FFF, {4'h0, volt});
    chk("due", 16'h0100, charge);
    u_bgc_host_model.hold_low(260);
    chk("asleep", 16'h0001, {15'h0000, sleep_active});
    adc <= 13'h0123;
    repeat (150) @(posedge clk);
    chk("halted", 16'h0FFF, {4'h0, volt});
    u_bgc_host_model.stop();
    chk("awake", 16'h0001, {15'h0000, gauge_run});
    repeat (200) @(posedge clk);
    rd_chk("resumed", REG_VOLT, 16'h0123);
    $display("test sleep finished");
    adc <= 13'h0456;
    sel <= 1'b1;
    ext_on <= 1'b1;
    r0 = n_restart;
    repeat (700) @(posedge clk);
    chk("ext_restart", 16'h0000, 16'(n_restart - r0));
    chk("ext_volt", 16'h0456, {4'h0, volt});
    sel <= 1'b0;
    ext_on <= 1'b0;
    $display("test external_clock finished");
    wr(REG_CMD, 16'h0055, 1'b1, nak);
    chk("reserved_cmd", 16'h1234, comp);
    wr(REG_CMD, CMD_FULL_RESET, 1'b1, nak);
    chk("reset_nak", 16'h0001, {15'h0000, nak});
    chk("reset_comp", COMP_RESET, comp);
    rd_chk("reset_read", REG_COMP, COMP_RESET);
    $display("test full_reset finished");
    close_out();
  end
endmodule : bgc_gauge_regs_tb_top

bind bgc_gauge_regs bgc_gauge_regs_assertions #(
  .OSC_DIV_P(OSC_DIV_P), .SLEEP_CYC_P(SLEEP_CYC_P), .FIRST_TICKS(FIRST_TICKS)
) u_bgc_gauge_regs_assertions (
  .clk(clk), .rst_b(rst_b), .scl_pin(scl_pin), .sda_in(sda_in), .sda_oe(sda_oe),
  .clock_select_pin(clock_select_pin), .clock_or_restart_pin(clock_or_restart_pin),
  .charge_raw(charge_raw), .charge_valid(charge_valid), .battery_voltage_result(battery_voltage_result),
  .charge_level_result(charge_level_result), .model_compensation(model_compensation),
  .estimate_restart(estimate_restart), .first_conversion(first_conversion),
  .gauge_run(gauge_run), .sleep_active(sleep_active)
);
